// File: design/uhs_top.sv
// Host strobe bus, modem pins and serial lines of a single UART channel
`default_nettype none
module uhs_top (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       cs_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] host_data_bus_in,
    output logic      [7:0] host_data_bus_out,
    output logic            host_data_bus_oe_n,
    input  wire logic       bus_isolate_in,
    output logic            int_out,
    output logic            int_oe_n,
    output logic            tx_out,
    input  wire logic       rx_in,
    output logic            rts_n,
    input  wire logic       cts_n,
    output logic            dtr_n,
    input  wire logic       dsr_n,
    input  wire logic       carrier_detect_n,
    input  wire logic       ring_indicator_n,
    output logic            thr_ready
);
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uhs_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uhs_rx_t;

    uhs_pkg::uhs_bus_t  bus_meta_r;
    uhs_pkg::uhs_bus_t  bus_s_r;
    uhs_pkg::uhs_bus_t  bus_cur;
    uhs_pkg::uhs_pins_t pin_meta_r;
    uhs_pkg::uhs_pins_t pin_s_r;
    logic               rd_prev_r;
    logic               wr_prev_r;
    logic               wr_armed_r;
    logic               rd_fall;
    logic               rd_rise;
    logic               wr_fall;
    logic               wr_rise;
    logic               bus_ok;
    logic               do_write;
    logic               rhr_read;

    logic [7:0] ier_r;
    logic [7:0] efr_r;
    logic [7:0] lcr_r;
    logic [7:0] mcr_r;
    logic [7:0] spr_r;
    logic [7:0] rhr_r;
    logic       rx_ready_r;
    logic       overrun_r;

    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    logic [7:0] fifo_out_data;

    uhs_tx_t    tx_state_r;
    logic [7:0] tx_shift_r;
    logic [2:0] tx_bit_r;
    logic [4:0] tx_cnt_r;
    logic       tx_level;
    uhs_rx_t    rx_state_r;
    logic [7:0] rx_shift_r;
    logic [2:0] rx_bit_r;
    logic [4:0] rx_cnt_r;
    logic       rx_bit;
    logic       cts_block;

    localparam logic [4:0] BIT_LAST  = 5'(uhs_pkg::BIT_CYC - 1);
    localparam logic [4:0] BIT_HALF  = 5'(uhs_pkg::BIT_CYC / 2 - 1);

    // Every input except ref_clk and nrst passes two flops; nothing reads the first stage
    assign bus_cur = '{cs_n: cs_n, rd_n: read_strobe_n, wr_n: write_strobe_n,
                       iso: bus_isolate_in, addr: reg_addr,
                       data: host_data_bus_in};

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bus_meta_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            bus_s_r    <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            pin_meta_r <= '1;
            pin_s_r    <= '1;
            rd_prev_r  <= 1'b1;
            wr_prev_r  <= 1'b1;
        end else begin
            bus_meta_r <= bus_cur;
            bus_s_r    <= bus_meta_r;
            pin_meta_r <= '{rx: rx_in, cts_n: cts_n, dsr_n: dsr_n,
                            cd_n: carrier_detect_n, ri_n: ring_indicator_n};
            pin_s_r    <= pin_meta_r;
            rd_prev_r  <= bus_s_r.rd_n;
            wr_prev_r  <= bus_s_r.wr_n;
        end
    end

    // Clock-free timing is impossible in this logic; strobes are sampled
    assign bus_ok  = !bus_s_r.cs_n && !bus_s_r.iso;
    assign rd_fall = rd_prev_r && !bus_s_r.rd_n;
    assign rd_rise = !rd_prev_r && bus_s_r.rd_n;
    assign wr_fall = wr_prev_r && !bus_s_r.wr_n;
    assign wr_rise = !wr_prev_r && bus_s_r.wr_n;
    assign do_write = wr_rise && wr_armed_r && bus_ok;
    assign rhr_read = rd_fall && bus_ok && bus_s_r.addr == uhs_pkg::ADDR_DATA;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_armed_r <= 1'b0;
        end else if (wr_fall) begin
            wr_armed_r <= bus_ok;
        end else if (wr_rise) begin
            wr_armed_r <= 1'b0;
        end
    end

    // Read data is frozen at the falling edge so the host sees a stable byte
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            host_data_bus_out  <= uhs_pkg::REG_RST;
            host_data_bus_oe_n <= 1'b1;
        end else if (rd_fall && bus_ok) begin
            host_data_bus_oe_n <= 1'b0;
            case (bus_s_r.addr)
                uhs_pkg::ADDR_DATA: host_data_bus_out <= rhr_r;
                uhs_pkg::ADDR_IER:  host_data_bus_out <= ier_r;
                uhs_pkg::ADDR_EFR:  host_data_bus_out <= efr_r;
                uhs_pkg::ADDR_LCR:  host_data_bus_out <= lcr_r;
                uhs_pkg::ADDR_MCR:  host_data_bus_out <= mcr_r;
                uhs_pkg::ADDR_LSR:  host_data_bus_out <= {1'b0,
                    tx_state_r == TX_IDLE && !fifo_out_valid,
                    !fifo_out_valid, !fifo_in_ready, 2'b00,
                    overrun_r, rx_ready_r};
                uhs_pkg::ADDR_MSR:  host_data_bus_out <= {~pin_s_r.cd_n,
                    ~pin_s_r.ri_n, ~pin_s_r.dsr_n, ~pin_s_r.cts_n, 4'h0};
                default:            host_data_bus_out <= spr_r;
            endcase
        end else if (rd_rise || bus_s_r.cs_n || bus_s_r.iso) begin
            host_data_bus_oe_n <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ier_r <= uhs_pkg::REG_RST;
            efr_r <= uhs_pkg::REG_RST;
            lcr_r <= uhs_pkg::REG_RST;
            mcr_r <= uhs_pkg::REG_RST;
            spr_r <= uhs_pkg::REG_RST;
        end else if (do_write) begin
            case (bus_s_r.addr)
                uhs_pkg::ADDR_IER: ier_r <= bus_s_r.data;
                uhs_pkg::ADDR_EFR: efr_r <= bus_s_r.data;
                uhs_pkg::ADDR_LCR: lcr_r <= bus_s_r.data;
                uhs_pkg::ADDR_MCR: mcr_r <= bus_s_r.data;
                uhs_pkg::ADDR_SPR: spr_r <= bus_s_r.data;
                default: ;
            endcase
        end
    end

    // A write to a full holding FIFO is dropped and flagged as overrun
    assign fifo_in_valid = do_write && bus_s_r.addr == uhs_pkg::ADDR_DATA;

    uhs_fifo #(
        .WIDTH (uhs_pkg::DATA_W),
        .DEPTH (uhs_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (bus_s_r.data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign cts_block = efr_r[uhs_pkg::EFR_AUTO_CTS]
                       && pin_s_r.cts_n;
    assign fifo_out_ready = tx_state_r == TX_IDLE && !cts_block;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_state_r <= TX_IDLE;
            tx_shift_r <= '0;
            tx_bit_r   <= '0;
            tx_cnt_r   <= '0;
        end else begin
            tx_cnt_r <= (tx_cnt_r == BIT_LAST) ? 5'h00 : 5'(tx_cnt_r + 1'b1);
            case (tx_state_r)
                TX_IDLE: begin
                    tx_cnt_r <= '0;
                    if (fifo_out_valid && !cts_block) begin
                        tx_shift_r <= fifo_out_data;
                        tx_state_r <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_cnt_r == BIT_LAST) begin
                        tx_state_r <= TX_DATA;
                        tx_bit_r   <= '0;
                    end
                end
                TX_DATA: begin
                    if (tx_cnt_r == BIT_LAST) begin
                        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        tx_bit_r   <= 3'(tx_bit_r + 1'b1);
                        if (tx_bit_r == 3'h7) begin
                            tx_state_r <= TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_cnt_r == BIT_LAST) begin
                        tx_state_r <= TX_IDLE;
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // Infrared path inverts the line so the inactive level is low
    always_comb begin
        case (tx_state_r)
            TX_START: tx_level = 1'b0;
            TX_DATA:  tx_level = tx_shift_r[0];
            default:  tx_level = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_out <= 1'b1;
        end else begin
            tx_out <= mcr_r[uhs_pkg::MCR_IR] ? ~tx_level : tx_level;
        end
    end

    assign rx_bit = mcr_r[uhs_pkg::MCR_IR] ? ~pin_s_r.rx : pin_s_r.rx;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_state_r <= RX_IDLE;
            rx_shift_r <= '0;
            rx_bit_r   <= '0;
            rx_cnt_r   <= '0;
        end else begin
            rx_cnt_r <= (rx_cnt_r == BIT_LAST) ? 5'h00 : 5'(rx_cnt_r + 1'b1);
            case (rx_state_r)
                RX_IDLE: begin
                    rx_cnt_r <= '0;
                    if (!rx_bit) begin
                        rx_state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_r == BIT_HALF) begin
                        rx_cnt_r   <= '0;
                        rx_bit_r   <= '0;
                        rx_state_r <= rx_bit ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_r == BIT_LAST) begin
                        rx_shift_r <= {rx_bit, rx_shift_r[7:1]};
                        rx_bit_r   <= 3'(rx_bit_r + 1'b1);
                        if (rx_bit_r == 3'h7) begin
                            rx_state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_r == BIT_LAST) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // New byte beats a simultaneous host read so no event is lost
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rhr_r      <= uhs_pkg::REG_RST;
            rx_ready_r <= 1'b0;
            overrun_r  <= 1'b0;
        end else begin
            if (rhr_read) begin
                rx_ready_r <= 1'b0;
            end
            if (rd_fall && bus_ok && bus_s_r.addr == uhs_pkg::ADDR_LSR) begin
                overrun_r <= 1'b0;
            end
            if (fifo_in_valid && !fifo_in_ready) begin
                overrun_r <= 1'b1;
            end
            if (rx_state_r == RX_STOP && rx_cnt_r == BIT_LAST && rx_bit) begin
                rhr_r      <= rx_shift_r;
                rx_ready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            int_out   <= 1'b0;
            int_oe_n  <= 1'b1;
            rts_n     <= 1'b1;
            dtr_n     <= 1'b1;
            thr_ready <= 1'b0;
        end else begin
            int_out   <= (ier_r[uhs_pkg::IER_RX] && rx_ready_r) ||
                         (ier_r[uhs_pkg::IER_TX] && !fifo_out_valid);
            int_oe_n  <= ~mcr_r[uhs_pkg::MCR_INT_OE];
            // Auto request drops while an unread byte waits
            rts_n     <= ~(mcr_r[uhs_pkg::MCR_RTS] &&
                           !(efr_r[uhs_pkg::EFR_AUTO_RTS] && rx_ready_r));
            dtr_n     <= ~mcr_r[uhs_pkg::MCR_DTR];
            thr_ready <= fifo_in_ready;
        end
    end
endmodule // uhs_top
`default_nettype wire

// File: shared/uhs_pkg.sv
// Constants and carrier types for the host-bus and serial-pin UART block
// Notes on behaviour
// - Read strobe falling edge fetches the addressed register and drives it out.
// - Write strobe falling edge starts a write; rising edge loads the byte.
// - Bus transactions are answered only while chip select is low.
// - Interrupt is active high, driven when modem control bit 3 set, else floated.
// - Standard mode: transmit output high in reset and when idle.
// - Modem control bit 6 selects infrared path; inactive serial level is low.
// - Clear-to-send is a plain input or gates the transmitter automatically.
// - Terminal-ready output and modem inputs are active low, usable as plain bits.
// - Reset returns every register and output to its default state.
// - During reset transmit stays high and receive input is ignored.
// - Power-save input isolates the host bus from the block.
// - Three address bits select one internal register per transaction.
// - Eight-bit data bus is driven only during reads.
// - Bus transactions are timed by chip select and strobes only; this logic samples them on ref_clk.
`default_nettype none
package uhs_pkg;
    localparam int          CLK_MHZ        = 100;
    localparam int          RST_MIN_NS     = 40;
    localparam int          RST_MIN_CYC    = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int          BIT_CYC        = 16;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          DATA_W         = 8;
    localparam logic [2:0]  ADDR_DATA      = 3'h0;
    localparam logic [2:0]  ADDR_IER       = 3'h1;
    localparam logic [2:0]  ADDR_EFR       = 3'h2;
    localparam logic [2:0]  ADDR_LCR       = 3'h3;
    localparam logic [2:0]  ADDR_MCR       = 3'h4;
    localparam logic [2:0]  ADDR_LSR       = 3'h5;
    localparam logic [2:0]  ADDR_MSR       = 3'h6;
    localparam logic [2:0]  ADDR_SPR       = 3'h7;
    localparam int          MCR_DTR        = 0;
    localparam int          MCR_RTS        = 1;
    localparam int          MCR_INT_OE     = 3;
    localparam int          MCR_IR         = 6;
    localparam int          EFR_AUTO_RTS   = 6;
    localparam int          EFR_AUTO_CTS   = 7;
    localparam int          IER_RX         = 0;
    localparam int          IER_TX         = 1;
    localparam int          IER_RTS        = 6;
    localparam int          IER_CTS        = 7;
    localparam int          LSR_DR         = 0;
    localparam int          LSR_OE         = 1;
    localparam int          LSR_THR_FULL   = 4;
    localparam int          LSR_THRE       = 5;
    localparam int          LSR_TEMT       = 6;
    localparam int          MSR_CTS        = 4;
    localparam logic [7:0]  REG_RST        = 8'h00;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       iso;
        logic [2:0] addr;
        logic [7:0] data;
    } uhs_bus_t;

    typedef struct packed {
        logic rx;
        logic cts_n;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
    } uhs_pins_t;
endpackage : uhs_pkg
`default_nettype wire

// File: design/uhs_fifo.sv
// Small FIFO with registered read data, valid and ready on both sides
`default_nettype none
module uhs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Output register holds one of the words, so at most DEPTH are kept
    assign in_ready = (AW+1)'(count_r + (AW+1)'(out_valid))
                      != (AW+1)'(DEPTH);
    assign push     = in_valid && in_ready;
    // Output register refills whenever a word is stored and it is empty or being taken
    assign pop      = (count_r != '0) && (!out_valid || out_ready);

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
            end
            if (pop) begin
                rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
            end
            count_r <= (AW+1)'(count_r + push - pop);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule // uhs_fifo
`default_nettype wire

// File: verif/uhs_top_monitor.sv
// Checker of host bus and serial pin timing for the UART block
`default_nettype none
module uhs_top_monitor (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic bus_isolate_in,
    input wire logic host_data_bus_oe_n,
    input wire logic int_out,
    input wire logic int_oe_n,
    input wire logic tx_out,
    input wire logic rts_n,
    input wire logic dtr_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence rd_fall_s;
        $fell(read_strobe_n) && !cs_n && !bus_isolate_in;
    endsequence
    sequence rd_hold_s;
        (!read_strobe_n && !cs_n && !bus_isolate_in)[*5];
    endsequence
    chk_read_drives_bus: assert property (
        rd_fall_s ##1 rd_hold_s |-> !host_data_bus_oe_n)
        else $error("read did not drive the data bus");
    chk_bus_release: assert property (
        $rose(read_strobe_n) |-> ##[1:5] host_data_bus_oe_n)
        else $error("data bus still driven after read");
    chk_no_select_quiet: assert property (
        cs_n[*5] |-> host_data_bus_oe_n)
        else $error("data bus driven without chip select");
    chk_isolate_quiet: assert property (
        bus_isolate_in[*5] |-> host_data_bus_oe_n)
        else $error("data bus driven while isolated");
    chk_write_no_drive: assert property (
        (!write_strobe_n && read_strobe_n)[*6] |-> host_data_bus_oe_n)
        else $error("data bus driven during write");
    // Terminal-ready and interrupt-enable pins only move six cycles after the write strobe was low
    chk_pin_after_write: assert property (
        ($changed(dtr_n) || $changed(int_oe_n)) && $past(nrst)
        |-> !$past(write_strobe_n, 6))
        else $error("control pin moved without a write");
    // Guards against a bit timer that reloads too early
    chk_tx_bit_width: assert property (
        $changed(tx_out) |=> $stable(tx_out)[*8])
        else $error("serial bit shorter than half a bit time");
    chk_reset_tx_high: assert property (
        disable iff (1'b0) !nrst |=> tx_out)
        else $error("transmit line not high in reset");
    chk_reset_defaults: assert property (
        disable iff (1'b0) !nrst |=> host_data_bus_oe_n && int_oe_n
        && rts_n && dtr_n && !int_out)
        else $error("outputs not at defaults in reset");
endmodule // uhs_top_monitor
bind uhs_top uhs_top_monitor u_uhs_top_monitor (
    .ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .bus_isolate_in(bus_isolate_in),
    .host_data_bus_oe_n(host_data_bus_oe_n), .int_out(int_out),
    .int_oe_n(int_oe_n), .tx_out(tx_out), .rts_n(rts_n), .dtr_n(dtr_n));
`default_nettype wire

// File: verif/uhs_host_model.sv
// Host processor model driving the asynchronous strobe bus
`default_nettype none
module uhs_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] bus_out,
    input  wire logic       bus_oe_n,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [2:0] addr,
    output logic      [7:0] bus_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv = 8'h00;
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 3'h0;
    end
    // A released bus shows the inverse of the last written byte, never a held copy
    assign bus_in = !bus_oe_n ? bus_out : drv;
    task automatic write_reg(input logic [2:0] a, input logic [7:0] d,
                             input logic sel);
        @(negedge ref_clk);
        cs_n = ~sel;
        addr = a;
        drv = d;
        repeat (2) @(negedge ref_clk);
        wr_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        wr_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        cs_n = 1'b1;
        drv = ~d;
    endtask
    task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        cs_n = 1'b0;
        addr = a;
        repeat (2) @(negedge ref_clk);
        rd_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        d = bus_in;
        rd_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        cs_n = 1'b1;
    endtask
endmodule // uhs_host_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the UART host bus and serial pins
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       iso = 1'b0;
    logic       rx_in = 1'b1;
    logic       cts_n = 1'b1;
    logic       dsr_n = 1'b1;
    logic       cd_n = 1'b1;
    logic       ri_n = 1'b1;
    logic       cs_n, rd_n, wr_n, oe_n, int_out, int_oe_n;
    logic       tx_out, rts_n, dtr_n, thr_ready;
    logic [2:0] addr;
    logic [7:0] din, dout, rv;
    logic [2:0] ra [4] = '{uhs_pkg::ADDR_SPR, uhs_pkg::ADDR_LCR,
                           uhs_pkg::ADDR_IER, uhs_pkg::ADDR_EFR};
    logic [7:0] rw [4] = '{8'ha5, 8'h3c, 8'h41, 8'h80};
    logic [3:0] pat [3] = '{4'ha, 4'h5, 4'hf};
    int         n_errors = 0;
    int         n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    uhs_host_model u_uhs_host_model (.ref_clk(ref_clk), .bus_out(dout),
        .bus_oe_n(oe_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .bus_in(din));
    uhs_top u_uhs_top (.ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .reg_addr(addr),
        .host_data_bus_in(din), .host_data_bus_out(dout),
        .host_data_bus_oe_n(oe_n), .bus_isolate_in(iso),
        .int_out(int_out), .int_oe_n(int_oe_n), .tx_out(tx_out),
        .rx_in(rx_in), .rts_n(rts_n), .cts_n(cts_n), .dtr_n(dtr_n),
        .dsr_n(dsr_n), .carrier_detect_n(cd_n),
        .ring_indicator_n(ri_n), .thr_ready(thr_ready));
    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [9:0] exp,
                         input logic [9:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_uhs_host_model.write_reg(a, d, 1'b1);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] m,
                      input logic [7:0] e, input string w);
        u_uhs_host_model.read_reg(a, rv);
        check(w, {2'b00, e}, {2'b00, rv & m});
    endtask
    // Catching the start bit late only shifts sampling by a few cycles
    task automatic frame(input logic [7:0] b, input logic inv);
        int         k;
        logic [9:0] seen;
        k = 0;
        while (tx_out !== inv && k < 3000) begin
            @(negedge ref_clk);
            k++;
        end
        cyc(8);
        for (int i = 0; i < 10; i++) begin
            seen[i] = tx_out ^ inv;
            cyc(16);
        end
        check("tx frame", {1'b1, b, 1'b0}, seen);
    endtask
    task automatic send_rx(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_in = f[i];
            cyc(16);
        end
    endtask
    initial begin
        #100us;
        n_errors++;
        complete_run();
    end
    initial begin
        cyc(2);
        rx_in = 1'b0;
        cyc(2);
        check("reset pins", 10'h03e,
              10'({tx_out, oe_n, int_oe_n, rts_n, dtr_n, int_out}));
        rx_in = 1'b1;
        nrst = 1'b1;
        cyc(2);
        rd(uhs_pkg::ADDR_LSR, 8'h01, 8'h00, "rx ignored in reset");
        for (int i = 0; i < 4; i++) rd(ra[i], 8'hff, 8'h00, "reset reg");
        for (int i = 0; i < 4; i++) wr(ra[i], rw[i]);
        for (int i = 0; i < 4; i++) rd(ra[i], 8'hff, rw[i], "readback");
        wr(uhs_pkg::ADDR_MSR, 8'hff);
        rd(uhs_pkg::ADDR_MSR, 8'hff, 8'h00, "msr read only");
        u_uhs_host_model.write_reg(uhs_pkg::ADDR_SPR, 8'h11, 1'b0);
        iso = 1'b1;
        wr(uhs_pkg::ADDR_SPR, 8'h22);
        u_uhs_host_model.read_reg(uhs_pkg::ADDR_SPR, rv);
        check("isolated read", 10'h0dd, 10'(rv));
        iso = 1'b0;
        rd(uhs_pkg::ADDR_SPR, 8'hff, 8'ha5, "blocked write");
        wr(uhs_pkg::ADDR_MCR, 8'h0b);
        cyc(2);
        check("mcr pins", 10'h000,
              10'({dtr_n, rts_n, int_oe_n, int_out}));
        // Request line is asserted before automatic request control is on
        wr(uhs_pkg::ADDR_EFR, 8'hc0);
        for (int i = 0; i < 3; i++) begin
            {cd_n, ri_n, dsr_n, cts_n} = pat[i];
            cyc(4);
            rd(uhs_pkg::ADDR_MSR, 8'hff, {~pat[i], 4'h0}, "msr");
        end
        send_rx(8'h3c);
        cyc(4);
        check("auto request off", 10'h003, 10'({rts_n, int_out}));
        rd(uhs_pkg::ADDR_LSR, 8'h01, 8'h01, "data ready");
        rd(uhs_pkg::ADDR_DATA, 8'hff, 8'h3c, "rx byte");
        rd(uhs_pkg::ADDR_LSR, 8'h01, 8'h00, "data taken");
        check("request back on", 10'h000, 10'(rts_n));
        for (int i = 0; i < 9; i++) wr(uhs_pkg::ADDR_DATA, 8'h50 + 8'(i));
        check("fifo full", 10'h001, 10'({thr_ready, tx_out}));
        rd(uhs_pkg::ADDR_LSR, 8'h12, 8'h12, "overrun full");
        cts_n = 1'b0;
        frame(8'h50, 1'b0);
        cyc(8 * 170);
        rd(uhs_pkg::ADDR_LSR, 8'h32, 8'h20, "fifo empty");
        wr(uhs_pkg::ADDR_IER, 8'h02);
        cyc(2);
        check("empty interrupt", 10'h003, 10'({thr_ready, int_out}));
        wr(uhs_pkg::ADDR_MCR, 8'h4b);
        rx_in = 1'b0;
        cyc(3);
        check("ir idle", 10'h000, 10'(tx_out));
        wr(uhs_pkg::ADDR_DATA, 8'ha7);
        frame(8'ha7, 1'b1);
        wr(uhs_pkg::ADDR_MCR, 8'h03);
        rx_in = 1'b1;
        cyc(3);
        check("float interrupt", 10'h003, 10'({int_oe_n, tx_out}));
        complete_run();
    end
endmodule // testbench
`default_nettype wire
